// ===== mca_pkg.sv
// package: constants and carrier types for the alu, bit and skip datapath
package mca_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [6:0] TIMER_COUNT_ADDR = 7'h01;
  localparam logic [6:0] PORT_A_ADDR = 7'h05;
  localparam int NIB_BIT = 4;
  // opcode slices of the 14-bit word
  localparam logic [13:0] OPW_ADD_F = 14'h0700;
  localparam logic [13:0] OPW_AND_F = 14'h0500;
  localparam logic [13:0] MSK_F = 14'h3f00;
  localparam logic [13:0] OPW_BCLR = 14'h1000;
  localparam logic [13:0] OPW_BSET = 14'h1400;
  localparam logic [13:0] OPW_SKZ = 14'h1800;
  localparam logic [13:0] OPW_SKO = 14'h1c00;
  localparam logic [13:0] MSK_B = 14'h3c00;
  localparam logic [13:0] OPW_ADD_L = 14'h3e00;
  localparam logic [13:0] MSK_ADD_L = 14'h3e00;
  localparam logic [13:0] OPW_AND_L = 14'h3900;
  localparam logic [13:0] MSK_AND_L = 14'h3f00;

  typedef struct packed {
    logic [7:0] acc;
    logic carry;
    logic nib_carry;
    logic zero;
    logic [6:0] waddr;
    logic [7:0] wdata;
    logic wen;
    logic pre_clr;
    logic squash;
    logic busy;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
  } mca_state_t;

  typedef struct packed {
    logic carry;
    logic nib_carry;
    logic zero;
  } mca_flags_t;
endpackage

// ===== mca_core.sv
// datapath for literal/file add and and, bit set/clear and bit skip tests
// Operation
// - port rewrite uses sampled pin levels
// - write to timer count clears assigned prescaler
// - pc change or true test costs two cycles
// - literal add updates acc and carry, nibble, zero
// - file add updates carry, nibble carry, zero
// - destination bit picks acc or file register
// - literal and writes acc, only zero flag
// - file and routes by destination, zero only
// - bit clear zeroes one bit, no flags
// - bit set raises one bit, no flags
// - skip if bit zero squashes next instruction
// - skip if bit one squashes next instruction
`timescale 1ns/1ps
module mca_core (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic instr_valid_i,
  input wire logic [13:0] instr_i,
  input wire logic pc_change_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic [7:0] port_a_pins_i,
  input wire logic pre_on_timer_i,
  output logic [7:0] acc_o,
  output mca_pkg::mca_flags_t flags_o,
  output logic [6:0] file_waddr_o,
  output logic [7:0] file_wdata_o,
  output logic file_we_o,
  output logic prescaler_clr_o,
  output logic nop_cycle_o
);
  mca_pkg::mca_state_t st_ff;
  mca_pkg::mca_state_t nxt_st;

  function automatic logic hit(input logic [13:0] w, input logic [13:0] m,
                               input logic [13:0] p);
    hit = (w & m) == p;
  endfunction

  logic [6:0] faddr;
  logic [2:0] bsel;
  logic dsel;
  logic [7:0] fsrc;
  logic [7:0] kval;
  logic [8:0] sum;
  logic [4:0] nsum;
  logic [7:0] addend;
  logic is_addl;
  logic is_andl;
  logic is_addf;
  logic is_andf;
  logic is_bclr;
  logic is_bset;
  logic is_skz;
  logic is_sko;
  logic [7:0] res;
  logic do_exec;

  always_comb begin
    faddr = instr_i[6:0];
    bsel = instr_i[9:7];
    dsel = instr_i[7];
    kval = instr_i[7:0];
    // read-modify-write of the port sees the pins, not the latch
    fsrc = (faddr == mca_pkg::PORT_A_ADDR) ? st_ff.pin_s2
                                           : file_rdata_i;
    do_exec = instr_valid_i && !st_ff.squash && !st_ff.busy;
    is_addl = do_exec && hit(instr_i, mca_pkg::MSK_ADD_L, mca_pkg::OPW_ADD_L);
    is_andl = do_exec && hit(instr_i, mca_pkg::MSK_AND_L, mca_pkg::OPW_AND_L);
    is_addf = do_exec && hit(instr_i, mca_pkg::MSK_F, mca_pkg::OPW_ADD_F);
    is_andf = do_exec && hit(instr_i, mca_pkg::MSK_F, mca_pkg::OPW_AND_F);
    is_bclr = do_exec && hit(instr_i, mca_pkg::MSK_B, mca_pkg::OPW_BCLR);
    is_bset = do_exec && hit(instr_i, mca_pkg::MSK_B, mca_pkg::OPW_BSET);
    is_skz = do_exec && hit(instr_i, mca_pkg::MSK_B, mca_pkg::OPW_SKZ);
    is_sko = do_exec && hit(instr_i, mca_pkg::MSK_B, mca_pkg::OPW_SKO);
    addend = is_addl ? kval : fsrc;
    sum = {1'b0, st_ff.acc} + {1'b0, addend};
    nsum = {1'b0, st_ff.acc[3:0]} + {1'b0, addend[3:0]};
    res = 8'h00;
    if (is_addl || is_addf) begin
      res = sum[7:0];
    end else if (is_andl) begin
      res = st_ff.acc & kval;
    end else if (is_andf) begin
      res = st_ff.acc & fsrc;
    end else if (is_bclr) begin
      res = fsrc & ~(8'h01 << bsel);
    end else if (is_bset) begin
      res = fsrc | (8'h01 << bsel);
    end

    nxt_st = st_ff;
    // pins come from outside: two flops before use
    nxt_st.pin_s1 = port_a_pins_i;
    nxt_st.pin_s2 = st_ff.pin_s1;
    nxt_st.wen = 1'b0;
    nxt_st.pre_clr = 1'b0;
    nxt_st.waddr = faddr;
    nxt_st.wdata = res;
    // one squashed cycle then back to normal issue
    nxt_st.squash = 1'b0;
    nxt_st.busy = 1'b0;
    if (is_addl || is_andl) begin
      nxt_st.acc = res;
    end
    if (is_addf || is_andf) begin
      if (dsel) begin
        nxt_st.wen = 1'b1;
      end else begin
        nxt_st.acc = res;
      end
    end
    if (is_bclr || is_bset) begin
      nxt_st.wen = 1'b1;
    end
    if (is_addl || is_addf) begin
      nxt_st.carry = sum[8];
      nxt_st.nib_carry = nsum[mca_pkg::NIB_BIT];
    end
    if (is_addl || is_addf || is_andl || is_andf) begin
      nxt_st.zero = (res == 8'h00);
    end
    if (nxt_st.wen && faddr == mca_pkg::TIMER_COUNT_ADDR && pre_on_timer_i) begin
      nxt_st.pre_clr = 1'b1;
    end
    if ((is_skz && !fsrc[bsel]) || (is_sko && fsrc[bsel])) begin
      nxt_st.squash = 1'b1;
    end
    // squash marks every no-op cycle so the nop output is one flop
    if (do_exec && pc_change_i) begin
      nxt_st.busy = 1'b1;
      nxt_st.squash = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_ff <= '0;
      st_ff.acc <= mca_pkg::ACC_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign acc_o = st_ff.acc;
  assign flags_o = '{carry: st_ff.carry, nib_carry: st_ff.nib_carry,
                     zero: st_ff.zero};
  assign file_waddr_o = st_ff.waddr;
  assign file_wdata_o = st_ff.wdata;
  assign file_we_o = st_ff.wen;
  assign prescaler_clr_o = st_ff.pre_clr;
  assign nop_cycle_o = st_ff.squash;

  skip_nop_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (is_skz && !fsrc[bsel]) |=> nop_cycle_o && !file_we_o)
    else $error("skip if zero did not squash");
  skip_keep_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (is_skz && fsrc[bsel] && !pc_change_i) |=> !nop_cycle_o && !file_we_o)
    else $error("skip if zero squashed with bit set");
  skip_one_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (is_sko && fsrc[bsel]) |=> nop_cycle_o && $stable(flags_o))
    else $error("skip if one did not squash");
  two_cycle_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    nop_cycle_o |=> !nop_cycle_o)
    else $error("no-op cycle lasted more than one cycle");
  pc_nop_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (do_exec && pc_change_i) |=> nop_cycle_o)
    else $error("pc change did not take two cycles");
  nop_idle_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    nop_cycle_o |=> !file_we_o && $stable(acc_o) && $stable(flags_o))
    else $error("no-op cycle changed state");
  addl_acc_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    is_addl |=> acc_o == $past(st_ff.acc) + $past(kval))
    else $error("literal add result wrong");
  addl_zero_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    is_addl |=> flags_o.zero == (acc_o == 8'h00))
    else $error("literal add zero flag wrong");
  add_carry_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (is_addf || is_addl) |=> flags_o.carry
      == ({1'b0, $past(st_ff.acc)} + {1'b0, $past(addend)} > 9'h0ff))
    else $error("add carry wrong");
  nib_carry_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (is_addf || is_addl) |=> flags_o.nib_carry
      == (5'($past(st_ff.acc[3:0])) + 5'($past(addend[3:0])) > 5'h0f))
    else $error("nibble carry wrong");
  dest_file_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    ((is_addf || is_andf) && dsel) |=> file_we_o && $stable(acc_o))
    else $error("file destination not honoured");
  dest_acc_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    ((is_addf || is_andf) && !dsel) |=> !file_we_o
      && acc_o == file_wdata_o)
    else $error("acc destination not honoured");
  andl_flags_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    is_andl |=> $stable(flags_o.carry) && $stable(flags_o.nib_carry))
    else $error("literal and touched carries");
  andl_acc_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    is_andl |=> acc_o == ($past(st_ff.acc) & $past(kval)))
    else $error("literal and result wrong");
  andf_zero_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    is_andf |=> flags_o.zero == (file_wdata_o == 8'h00))
    else $error("file and zero flag wrong");
  bit_clear_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    is_bclr |=> file_we_o && !file_wdata_o[$past(bsel)]
      && $stable(flags_o))
    else $error("bit clear wrong");
  bit_set_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    is_bset |=> file_we_o && file_wdata_o[$past(bsel)])
    else $error("bit set wrong");
  bit_keep_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    is_bset |=> $stable(flags_o) && $stable(acc_o))
    else $error("bit set touched acc or flags");
  port_pins_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (is_addf && faddr == mca_pkg::PORT_A_ADDR) |=> file_wdata_o
      == $past(st_ff.acc) + $past(st_ff.pin_s2))
    else $error("port rewrite did not use pins");
  pre_clear_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (prescaler_clr_o |-> file_we_o
      && file_waddr_o == mca_pkg::TIMER_COUNT_ADDR))
    else $error("prescaler cleared without timer write");
  pre_set_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    ((is_addf || is_andf) && dsel && faddr == mca_pkg::TIMER_COUNT_ADDR
      && pre_on_timer_i) |=> prescaler_clr_o)
    else $error("timer write did not clear prescaler");
endmodule

// ===== mca_file_model.sv
// file register space model answering the datapath's reads and writes
`timescale 1ns/1ps
module mca_file_model (
  input wire logic sys_clk_i,
  input wire logic [6:0] raddr_i,
  output logic [7:0] rdata_o,
  input wire logic we_i,
  input wire logic [6:0] waddr_i,
  input wire logic [7:0] wdata_i
);
  logic [7:0] mem_ff [128];
  // each register starts out holding its own address
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem_ff[i] = 8'(i);
    end
  end
  assign rdata_o = mem_ff[raddr_i];
  always @(posedge sys_clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end
endmodule

// ===== test_mcu_core_alu_bit_skip_ops.sv
// self-checking bench for the alu, bit and skip datapath
`timescale 1ns/1ps
module test_mcu_core_alu_bit_skip_ops;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic vld = 1'b0;
  logic pc = 1'b0;
  logic pre_on = 1'b0;
  logic [13:0] ins = 14'h0000;
  logic [7:0] pins = 8'ha5;
  logic [7:0] rd, acc, wd;
  logic [6:0] wa;
  logic we, pclr, nop;
  mca_pkg::mca_flags_t fl;
  int n_mismatch = 0;
  int check_count = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  mca_core DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .instr_valid_i(vld), .instr_i(ins), .pc_change_i(pc),
    .file_rdata_i(rd), .port_a_pins_i(pins), .pre_on_timer_i(pre_on),
    .acc_o(acc), .flags_o(fl), .file_waddr_o(wa), .file_wdata_o(wd),
    .file_we_o(we), .prescaler_clr_o(pclr), .nop_cycle_o(nop));
  mca_file_model files (.sys_clk_i(sys_clk_i), .raddr_i(ins[6:0]),
    .rdata_o(rd), .we_i(we), .waddr_i(wa), .wdata_i(wd));
  // c is {write, prescaler clear, nop}; address and data only if written
  task automatic x(input logic [13:0] w, input logic p,
      input logic [7:0] ea, input logic [2:0] ef, input logic [2:0] c,
      input logic [6:0] ewa, input logic [7:0] ewd);
    @(negedge sys_clk_i);
    vld = 1'b1;
    ins = w;
    pc = p;
    @(negedge sys_clk_i);
    vld = 1'b0;
    pc = 1'b0;
    check_count++;
    if ({acc, fl, we, pclr, nop} !== {ea, ef, c} ||
        (c[2] && {wa, wd} !== {ewa, ewd})) begin
      n_mismatch++;
      $display("wrong value at %0t: instr %h", $time, w);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge sys_clk_i);
    reset_i = 1'b0;
    x(14'h3ef8, 1'b0, 8'hf8, 3'h0, 3'h0, 7'h00, 8'h00);
    x(14'h3e0f, 1'b0, 8'h07, 3'h6, 3'h0, 7'h00, 8'h00);
    x(14'h3904, 1'b0, 8'h04, 3'h6, 3'h0, 7'h00, 8'h00);
    x(14'h3900, 1'b0, 8'h00, 3'h7, 3'h0, 7'h00, 8'h00);
    x(14'h05b0, 1'b0, 8'h00, 3'h7, 3'h4, 7'h30, 8'h00);
    x(14'h0710, 1'b0, 8'h10, 3'h0, 3'h0, 7'h00, 8'h00);
    x(14'h07a0, 1'b0, 8'h10, 3'h0, 3'h4, 7'h20, 8'h30);
    for (int b = 0; b < 8; b++) begin
      x(14'h1400 | (14'(b) << 7), 1'b0, 8'h10, 3'h0, 3'h4, 7'h00,
        8'((9'h002 << b) - 1));
    end
    for (int b = 0; b < 8; b++) begin
      x(14'h1000 | (14'(b) << 7), 1'b0, 8'h10, 3'h0, 3'h4, 7'h00,
        8'(16'h00ff << (b + 1)));
    end
    x(14'h1882, 1'b0, 8'h10, 3'h0, 3'h0, 7'h00, 8'h00);
    // skip taken, then an add offered in the squashed cycle is dropped
    @(negedge sys_clk_i);
    vld = 1'b1;
    ins = 14'h1802;
    @(negedge sys_clk_i);
    ins = 14'h3e01;
    check_count++;
    if ({acc, fl, we, pclr, nop} !== {8'h10, 3'h0, 3'h1}) begin
      n_mismatch++;
      $display("wrong value at %0t: bit zero skip", $time);
    end
    @(negedge sys_clk_i);
    vld = 1'b0;
    x(14'h1c82, 1'b0, 8'h10, 3'h0, 3'h1, 7'h00, 8'h00);
    x(14'h1c02, 1'b0, 8'h10, 3'h0, 3'h0, 7'h00, 8'h00);
    x(14'h3e00, 1'b1, 8'h10, 3'h0, 3'h1, 7'h00, 8'h00);
    x(14'h0785, 1'b0, 8'h10, 3'h0, 3'h4, 7'h05, 8'hb5);
    pre_on = 1'b1;
    pins = 8'h01;
    x(14'h1781, 1'b0, 8'h10, 3'h0, 3'h6, 7'h01, 8'h81);
    x(14'h0701, 1'b0, 8'h91, 3'h0, 3'h0, 7'h00, 8'h00);
    pre_on = 1'b0;
    x(14'h0781, 1'b0, 8'h91, 3'h4, 3'h4, 7'h01, 8'h12);
    x(14'h1785, 1'b0, 8'h91, 3'h4, 3'h4, 7'h05, 8'h81);
    stop_test();
  end
endmodule
